// ===== logic/dcwd_pkg.sv
// Constants for the configuration word decoder: addresses, field positions,
// erased values and clock select codes.
// Assumes a 14-bit program-space word and address path from programming logic.
//
// Notes on behaviour
// - First configuration word lives at 2007h, second at 2008h.
// - Configuration words reachable only in programming mode, never by running code.
// - Bit 13 low enables debugger and dedicates serial clock/data pins.
// - Bit 12 selects internal oscillator: 0 is 500 kHz, 1 is 16 MHz.
// - Bit 10 selects brown-out trip: 0 is 2.5 V, 1 is 1.9 V.
// - Bits 9-8: 0x off, 10 on except sleep, 11 always on.
// - Power-up timer depends only on its own bit, not on brown-out.
// - Bit 6 low enables code protection, high leaves memory readable.
// - Turning code protection off erases the whole program memory.
// - Unprotected program memory may be read by the programmer for verify.
// - Bit 5 high makes master-clear a reset pin, low a digital input; code drives master_clear_digital_in from the pin in both settings.
// - Master-clear asserted with internal or RC clock stops internal oscillator.
// - Bit 4 low enables power-up timer, high disables it.
// - Bit 3 high enables watchdog, low disables it.
// - Code 111 RC with clock out, 110 RC with pin as I/O.
// - Code 101 internal with clock out, 100 internal with both pins I/O.
// - 011 external clock, 010 high-gain, 001 medium-gain, 000 low-power crystal.
// - Unimplemented bits of both words read back as one.
// - Regulated part: bits 5-4 place capacitor on A0, A5, A6 or none.
// - Unregulated part ignores the capacitor field, all capacitor pins off.
// - Four user ID words at 2000h-2003h, only in program/verify mode.

package dcwd_pkg;

    localparam int unsigned WORD_W = 14;
    localparam int unsigned ADDR_W = 14;

    localparam logic [ADDR_W-1:0] ADDR_CFG_ONE  = 14'h2007;
    localparam logic [ADDR_W-1:0] ADDR_CFG_TWO  = 14'h2008;
    localparam logic [ADDR_W-1:0] ADDR_USER_ID0 = 14'h2000;
    localparam logic [ADDR_W-1:0] ADDR_USER_ID3 = 14'h2003;
    localparam int unsigned       USER_ID_NUM   = 4;

    localparam logic [WORD_W-1:0] WORD_ERASED   = 14'h3FFF;
    localparam logic [WORD_W-1:0] CFG_ONE_UNIMP = 14'h0880;
    localparam logic [WORD_W-1:0] CFG_TWO_UNIMP = 14'h3FCF;
    localparam logic [WORD_W-1:0] READ_NONE     = 14'h0000;

    localparam int unsigned BIT_DEBUG_N      = 13;
    localparam int unsigned BIT_PLL_ON       = 12;
    localparam int unsigned BIT_BOR_TRIP     = 10;
    localparam int unsigned BIT_BOR_POL_HI   = 9;
    localparam int unsigned BIT_BOR_POL_LO   = 8;
    localparam int unsigned BIT_CP_N         = 6;
    localparam int unsigned BIT_MASTER_CLEAR_RESET_SEL     = 5;
    localparam int unsigned BIT_POWERUP_DELAY_TIMER_N       = 4;
    localparam int unsigned BIT_WDT_ON       = 3;
    localparam int unsigned BIT_FOSC_HI      = 2;
    localparam int unsigned BIT_FOSC_LO      = 0;
    localparam int unsigned BIT_REGULATOR_CAPACITOR_PIN_HI      = 5;
    localparam int unsigned BIT_REGULATOR_CAPACITOR_PIN_LO      = 4;

    localparam logic [1:0] BOR_POL_RUN_ONLY = 2'h2;
    localparam logic [1:0] BOR_POL_ALWAYS   = 2'h3;

    localparam logic [2:0] FOSC_RC_CLKOUT   = 3'h7;
    localparam logic [2:0] FOSC_RC_IO       = 3'h6;
    localparam logic [2:0] FOSC_INT_CLKOUT  = 3'h5;
    localparam logic [2:0] FOSC_INT_IO      = 3'h4;
    localparam logic [2:0] FOSC_EXT_CLOCK   = 3'h3;
    localparam logic [2:0] FOSC_HIGH_GAIN   = 3'h2;
    localparam logic [2:0] FOSC_MED_GAIN    = 3'h1;
    localparam logic [2:0] FOSC_LOW_GAIN    = 3'h0;

    localparam logic [1:0] REGULATOR_CAPACITOR_PIN_ON_A0  = 2'h0;
    localparam logic [1:0] REGULATOR_CAPACITOR_PIN_ON_A5  = 2'h1;
    localparam logic [1:0] REGULATOR_CAPACITOR_PIN_ON_A6  = 2'h2;

    localparam logic [1:0] XTAL_GAIN_NONE = 2'h0;
    localparam logic [1:0] XTAL_GAIN_LOW  = 2'h1;
    localparam logic [1:0] XTAL_GAIN_MED  = 2'h2;
    localparam logic [1:0] XTAL_GAIN_HIGH = 2'h3;

endpackage

// ===== logic/dcwd_decoder.sv
// Configuration word store and decoder: two configuration words, four user
// ID words, programming-mode access port and static decoded option outputs.
// Assumes the programming port comes from serial programming logic on mclk;
// only the master-clear pin arrives from outside and is synchronised.

module dcwd_decoder #(
    parameter bit REGULATED = 1'b1
) (
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // Programming access
    input  wire logic                        prog_mode,
    input  wire logic [dcwd_pkg::ADDR_W-1:0] prog_addr,
    input  wire logic                        prog_wr,
    input  wire logic                        prog_rd,
    input  wire logic [dcwd_pkg::WORD_W-1:0] prog_wdata,
    output logic      [dcwd_pkg::WORD_W-1:0] prog_rdata,
    output logic                             prog_rvalid,
    output logic                             prog_mem_erase,
    output logic                             prog_mem_read_allow,
    // Master-clear pin
    input  wire logic                        master_clear_reset_pin_n,
    output logic                             master_clear_reset,
    output logic                             master_clear_digital_in,
    output logic                             internal_osc_stop,
    // Decoded static options
    output logic                             debugger_on,
    output logic                             serial_pins_gpio,
    output logic                             internal_osc_multiplier_on,
    output logic                             brownout_trip_select,
    output logic                             brownout_run_on,
    output logic                             brownout_sleep_on,
    output logic                             code_read_protect_n,
    output logic                             master_clear_pin_select,
    output logic                             powerup_delay_enable,
    output logic                             watchdog_on,
    output logic      [2:0]                  osc_select,
    output logic                             osc2_clk_output,
    output logic                             osc2_is_io,
    output logic                             osc1_is_io,
    output logic      [1:0]                  crystal_gain,
    output logic      [2:0]                  regulator_cap_pin_on
);

    // ------------------------------------------------------------
    // Word storage
    // ------------------------------------------------------------
    // Nonvolatile cells: nrst leaves them alone and only restarts the
    // snapshot, so a programmed word takes effect at the next reset.
    logic [dcwd_pkg::WORD_W-1:0] config_word_one = dcwd_pkg::WORD_ERASED;
    logic [dcwd_pkg::WORD_W-1:0] config_word_two = dcwd_pkg::WORD_ERASED;
    logic [dcwd_pkg::WORD_W-1:0] user_id [dcwd_pkg::USER_ID_NUM]
                                 = '{default: dcwd_pkg::WORD_ERASED};

    // ------------------------------------------------------------
    // Programming address decode
    // ------------------------------------------------------------
    logic hit_one;
    logic hit_two;
    logic hit_id;
    logic [1:0] id_index;

    assign hit_one  = (prog_addr == dcwd_pkg::ADDR_CFG_ONE);
    assign hit_two  = (prog_addr == dcwd_pkg::ADDR_CFG_TWO);
    assign hit_id   = (prog_addr >= dcwd_pkg::ADDR_USER_ID0)
                   && (prog_addr <= dcwd_pkg::ADDR_USER_ID3);
    assign id_index = prog_addr[1:0];

    // Unimplemented positions are forced high so they always read as one
    always_ff @(posedge mclk) begin
        if (prog_mode && prog_wr) begin
            if (hit_one) begin
                config_word_one <= prog_wdata | dcwd_pkg::CFG_ONE_UNIMP;
            end
            if (hit_two) begin
                config_word_two <= prog_wdata | dcwd_pkg::CFG_TWO_UNIMP;
            end
        end
    end

    // ID words are stored whole; strobes outside programming mode are dropped
    always_ff @(posedge mclk) begin
        if (prog_mode && prog_wr && hit_id) begin
            user_id[id_index] <= prog_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read-back of configuration and ID words
    // ------------------------------------------------------------
    // Answer strobe follows each programming-mode read-strobe cycle one cycle later; the word stays until the next such read or reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prog_rvalid <= 1'b0;
        end else begin
            prog_rvalid <= prog_rd && prog_mode;
        end
    end

    // Unmapped reads answer zero, so a verify pass never sees a stale word
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prog_rdata <= dcwd_pkg::READ_NONE;
        end else if (prog_rd && prog_mode) begin
            if (hit_one) begin
                prog_rdata <= config_word_one;
            end else if (hit_two) begin
                prog_rdata <= config_word_two;
            end else if (hit_id) begin
                prog_rdata <= user_id[id_index];
            end else begin
                prog_rdata <= dcwd_pkg::READ_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Protection effects
    // ------------------------------------------------------------
    // Erase fires only on a protected-to-unprotected transition
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prog_mem_erase <= 1'b0;
        end else begin
            prog_mem_erase <= prog_mode && prog_wr && hit_one
                           && !config_word_one[dcwd_pkg::BIT_CP_N]
                           && prog_wdata[dcwd_pkg::BIT_CP_N];
        end
    end

    // Follows the stored word so a fresh erase reopens verify at once
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prog_mem_read_allow <= 1'b0;
        end else begin
            prog_mem_read_allow <= prog_mode
                                && config_word_one[dcwd_pkg::BIT_CP_N];
        end
    end

    // ------------------------------------------------------------
    // Snapshot at reset release
    // ------------------------------------------------------------
    logic                        cfg_loaded;
    logic [dcwd_pkg::WORD_W-1:0] snap_one;
    logic [dcwd_pkg::WORD_W-1:0] snap_two;

    // Later programming writes do not move the options until next reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_loaded <= 1'b0;
            snap_one   <= dcwd_pkg::WORD_ERASED;
            snap_two   <= dcwd_pkg::WORD_ERASED;
        end else if (!cfg_loaded) begin
            cfg_loaded <= 1'b1;
            snap_one   <= config_word_one;
            snap_two   <= config_word_two;
        end
    end

    logic [2:0] fosc;
    logic [1:0] bor_pol;
    logic [1:0] regulator_capacitor_pin;

    assign fosc    = snap_one[dcwd_pkg::BIT_FOSC_HI:dcwd_pkg::BIT_FOSC_LO];
    assign bor_pol = snap_one[dcwd_pkg::BIT_BOR_POL_HI:dcwd_pkg::BIT_BOR_POL_LO];
    assign regulator_capacitor_pin    = snap_two[dcwd_pkg::BIT_REGULATOR_CAPACITOR_PIN_HI:dcwd_pkg::BIT_REGULATOR_CAPACITOR_PIN_LO];

    // ------------------------------------------------------------
    // Decoded options
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            debugger_on                <= 1'b0;
            serial_pins_gpio           <= 1'b1;
            internal_osc_multiplier_on <= 1'b1;
            brownout_trip_select       <= 1'b1;
            brownout_run_on            <= 1'b1;
            brownout_sleep_on          <= 1'b1;
            code_read_protect_n        <= 1'b1;
            master_clear_pin_select    <= 1'b1;
            powerup_delay_enable       <= 1'b0;
            watchdog_on                <= 1'b1;
        end else begin
            debugger_on                <= !snap_one[dcwd_pkg::BIT_DEBUG_N];
            serial_pins_gpio           <= snap_one[dcwd_pkg::BIT_DEBUG_N];
            internal_osc_multiplier_on <= snap_one[dcwd_pkg::BIT_PLL_ON];
            brownout_trip_select       <= snap_one[dcwd_pkg::BIT_BOR_TRIP];
            brownout_run_on            <= (bor_pol == dcwd_pkg::BOR_POL_RUN_ONLY)
                                       || (bor_pol == dcwd_pkg::BOR_POL_ALWAYS);
            brownout_sleep_on          <= (bor_pol == dcwd_pkg::BOR_POL_ALWAYS);
            code_read_protect_n        <= snap_one[dcwd_pkg::BIT_CP_N];
            master_clear_pin_select    <= snap_one[dcwd_pkg::BIT_MASTER_CLEAR_RESET_SEL];
            // Brown-out bits take no part here
            powerup_delay_enable       <= !snap_one[dcwd_pkg::BIT_POWERUP_DELAY_TIMER_N];
            watchdog_on                <= snap_one[dcwd_pkg::BIT_WDT_ON];
        end
    end

    // ------------------------------------------------------------
    // Oscillator pin roles
    // ------------------------------------------------------------
    // Crystal modes hand both pins to the resonator, so neither is I/O
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            osc_select      <= dcwd_pkg::FOSC_RC_CLKOUT;
            osc2_clk_output <= 1'b1;
            osc2_is_io      <= 1'b0;
            osc1_is_io      <= 1'b0;
            crystal_gain    <= dcwd_pkg::XTAL_GAIN_NONE;
        end else begin
            osc_select <= fosc;
            case (fosc)
                dcwd_pkg::FOSC_RC_CLKOUT, dcwd_pkg::FOSC_INT_CLKOUT: begin
                    osc2_clk_output <= 1'b1;
                    osc2_is_io      <= 1'b0;
                    osc1_is_io      <= (fosc == dcwd_pkg::FOSC_INT_CLKOUT);
                    crystal_gain    <= dcwd_pkg::XTAL_GAIN_NONE;
                end
                dcwd_pkg::FOSC_RC_IO, dcwd_pkg::FOSC_INT_IO, dcwd_pkg::FOSC_EXT_CLOCK: begin
                    osc2_clk_output <= 1'b0;
                    osc2_is_io      <= 1'b1;
                    osc1_is_io      <= (fosc == dcwd_pkg::FOSC_INT_IO);
                    crystal_gain    <= dcwd_pkg::XTAL_GAIN_NONE;
                end
                dcwd_pkg::FOSC_HIGH_GAIN: begin
                    osc2_clk_output <= 1'b0;
                    osc2_is_io      <= 1'b0;
                    osc1_is_io      <= 1'b0;
                    crystal_gain    <= dcwd_pkg::XTAL_GAIN_HIGH;
                end
                dcwd_pkg::FOSC_MED_GAIN: begin
                    osc2_clk_output <= 1'b0;
                    osc2_is_io      <= 1'b0;
                    osc1_is_io      <= 1'b0;
                    crystal_gain    <= dcwd_pkg::XTAL_GAIN_MED;
                end
                default: begin
                    osc2_clk_output <= 1'b0;
                    osc2_is_io      <= 1'b0;
                    osc1_is_io      <= 1'b0;
                    crystal_gain    <= dcwd_pkg::XTAL_GAIN_LOW;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Regulator capacitor placement
    // ------------------------------------------------------------
    // Code 11 is legal but leaves the regulator without its capacitor
    // Bit 0 is port A0, bit 1 port A5, bit 2 port A6
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regulator_cap_pin_on <= 3'h0;
        end else if (!REGULATED) begin
            regulator_cap_pin_on <= 3'h0;
        end else begin
            case (regulator_capacitor_pin)
                dcwd_pkg::REGULATOR_CAPACITOR_PIN_ON_A0: regulator_cap_pin_on <= 3'h1;
                dcwd_pkg::REGULATOR_CAPACITOR_PIN_ON_A5: regulator_cap_pin_on <= 3'h2;
                dcwd_pkg::REGULATOR_CAPACITOR_PIN_ON_A6: regulator_cap_pin_on <= 3'h4;
                default:              regulator_cap_pin_on <= 3'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Master-clear pin
    // ------------------------------------------------------------
    logic master_clear_reset_meta;
    logic master_clear_reset_sync;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            master_clear_reset_meta <= 1'b1;
            master_clear_reset_sync <= 1'b1;
        end else begin
            master_clear_reset_meta <= master_clear_reset_pin_n;
            master_clear_reset_sync <= master_clear_reset_meta;
        end
    end

    // Held off until the snapshot is valid so erased defaults cannot reset us
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            master_clear_reset      <= 1'b0;
            master_clear_digital_in <= 1'b1;
        end else begin
            master_clear_reset      <= cfg_loaded && snap_one[dcwd_pkg::BIT_MASTER_CLEAR_RESET_SEL]
                                    && !master_clear_reset_sync;
            master_clear_digital_in <= master_clear_reset_sync;
        end
    end

    // Codes 100..111 are the internal and RC sources; crystals keep running
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            internal_osc_stop <= 1'b0;
        end else begin
            internal_osc_stop <= cfg_loaded && snap_one[dcwd_pkg::BIT_MASTER_CLEAR_RESET_SEL]
                              && !master_clear_reset_sync && fosc[2];
        end
    end

endmodule

// ===== bench/dcwd_decoder_props.sv
// Checker for the configuration decoder: programming port and decoded outputs.
// Assumes one mclk domain; bound onto every dcwd_decoder by port name.
module dcwd_decoder_props (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic prog_mode,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic prog_rvalid,
    input wire logic prog_mem_erase,
    input wire logic prog_mem_read_allow,
    input wire logic master_clear_reset_pin_n,
    input wire logic master_clear_reset,
    input wire logic internal_osc_stop,
    input wire logic master_clear_pin_select,
    input wire logic debugger_on,
    input wire logic serial_pins_gpio
);
    timeunit 1ns;
    timeprecision 1ps;
    // Saturates so the decode is known settled long after release
    logic [2:0] since_rel;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            since_rel <= 3'h0;
        end else if (since_rel != 3'h7) begin
            since_rel <= since_rel + 3'h1;
        end
    end
    default clocking dcwd_cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_pin_low;
        !master_clear_reset_pin_n [*4];
    endsequence
    property p_rd_ans;
        prog_mode && prog_rd |=> prog_rvalid;
    endproperty
    property p_rd_refuse;
        !(prog_mode && prog_rd) |=> !prog_rvalid;
    endproperty
    property p_dbg;
        debugger_on != serial_pins_gpio;
    endproperty
    property p_erase;
        prog_mem_erase |-> $past(prog_mode && prog_wr);
    endproperty
    property p_allow;
        prog_mem_read_allow |-> $past(prog_mode);
    endproperty
    property p_osc_stop;
        internal_osc_stop |-> master_clear_reset;
    endproperty
    property p_master_clear_reset;
        s_pin_low ##0 (since_rel == 3'h7 && master_clear_pin_select) |-> master_clear_reset;
    endproperty
    property p_static;
        since_rel == 3'h7 |-> $stable(debugger_on) && $stable(master_clear_pin_select);
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_rd_refuse: assert property (p_rd_refuse) else $error("stray read valid");
    a_dbg: assert property (p_dbg) else $error("debug pin owner clash");
    a_erase: assert property (p_erase) else $error("erase without write");
    a_allow: assert property (p_allow) else $error("read allowed out of mode");
    a_osc_stop: assert property (p_osc_stop) else $error("osc stop without reset");
    a_master_clear_reset: assert property (p_master_clear_reset) else $error("master clear missed");
    a_static: assert property (p_static) else $error("decode changed");
endmodule

bind dcwd_decoder dcwd_decoder_props u_dcwd_decoder_props (.*);

// ===== bench/dcwd_prog_model.sv
// Serial programmer stand-in driving the programming port.
// Assumes strobes are sampled on the rising edge of mclk.
module dcwd_prog_model (
    input  wire logic        mclk,
    input  wire logic [13:0] prog_rdata,
    input  wire logic        prog_rvalid,
    output logic             prog_mode,
    output logic      [13:0] prog_addr,
    output logic             prog_wr,
    output logic             prog_rd,
    output logic      [13:0] prog_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        prog_mode = 1'b0;
        prog_addr = 14'h0000;
        prog_wr = 1'b0;
        prog_rd = 1'b0;
        prog_wdata = 14'h0000;
    end
    // Idle gap first; the bench always passes a gap of one cycle
    task automatic access(input logic m, input logic w, input logic [13:0] a,
                          input logic [13:0] d, input int gap,
                          output logic v, output logic [13:0] q);
        repeat (gap) @(posedge mclk);
        prog_mode <= m;
        prog_addr <= a;
        prog_wdata <= d;
        prog_wr <= w;
        prog_rd <= !w;
        @(posedge mclk);
        prog_wr <= 1'b0;
        prog_rd <= 1'b0;
        // Released lines must not keep looking valid
        prog_addr <= ~a;
        prog_wdata <= ~d;
        #1;
        v = prog_rvalid;
        q = prog_rdata;
    endtask
endmodule

// ===== bench/dcwd_decoder_tb_top.sv
// Self-checking bench for the configuration decoder.
// Assumes stored words survive an nrst pulse, which reloads the decode.
module dcwd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [13:0] w1; logic [13:0] w2; logic [20:0] dec;} dcwd_row_t;
    logic mclk, nrst, master_clear_reset_pin_n, prog_mode, prog_wr, prog_rd, prog_rvalid, v;
    logic [13:0] prog_addr, prog_wdata, prog_rdata, q;
    logic prog_mem_erase, prog_mem_read_allow, master_clear_reset, master_clear_digital_in;
    logic internal_osc_stop, debugger_on, serial_pins_gpio, internal_osc_multiplier_on;
    logic brownout_trip_select, brownout_run_on, brownout_sleep_on, code_read_protect_n;
    logic master_clear_pin_select, powerup_delay_enable, watchdog_on, osc2_clk_output;
    logic osc2_is_io, osc1_is_io;
    logic [2:0] osc_select, regulator_cap_pin_on;
    logic [1:0] crystal_gain;
    logic [20:0] dec;
    int n_errors = 0;
    int n_tests = 0;
    int seen = 0;
    dcwd_row_t rows [8] = '{'{14'h0000, 14'h0000, 21'h101009}, '{14'h1101, 14'h0010, 21'h141112},
        '{14'h0602, 14'h0020, 21'h13121C}, '{14'h030B, 14'h0030, 21'h119B40},
        '{14'h2314, 14'h0000, 21'h098461}, '{14'h0065, 14'h0000, 21'h1075A1},
        '{14'h0006, 14'h0000, 21'h101641}, '{14'h3FFF, 14'h3FFF, 21'h0FEF80}};
    assign dec = {debugger_on, serial_pins_gpio, internal_osc_multiplier_on, brownout_trip_select,
        brownout_run_on, brownout_sleep_on, code_read_protect_n, master_clear_pin_select,
        powerup_delay_enable, watchdog_on, osc_select, osc2_clk_output, osc2_is_io, osc1_is_io,
        crystal_gain, regulator_cap_pin_on};
    dcwd_decoder u_dcwd_decoder (.*);
    dcwd_prog_model u_dcwd_prog_model (.*);
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (prog_mem_erase === 1'b1) seen++;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    task automatic check_decode(input logic [20:0] e);
        check("core", 21'(dec[20:18]), 21'(e[20:18]));
        check("bor", 21'(dec[17:15]), 21'(e[17:15]));
        check("misc", 21'(dec[14:13]), 21'(e[14:13]));
        check("timers", 21'(dec[12:11]), 21'(e[12:11]));
        check("clk", 21'(dec[10:0]), 21'(e[10:0]));
    endtask
    task automatic wr(input logic m, input logic [13:0] a, input logic [13:0] d);
        u_dcwd_prog_model.access(m, 1'b1, a, d, 1, v, q);
    endtask
    task automatic rd(input logic m, input logic [13:0] a, input logic [13:0] e);
        u_dcwd_prog_model.access(m, 1'b0, a, 14'h0000, 1, v, q);
        check("read valid", 21'(v), 21'(m));
        if (m) check("read data", 21'(q), 21'(e));
    endtask
    task automatic pulse_reset;
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic master_clear_reset_low(input logic e);
        @(posedge mclk);
        master_clear_reset_pin_n <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        check("master_clear_reset reset", 21'(master_clear_reset), 21'(e));
        check("osc stop", 21'(internal_osc_stop), 21'(e));
        check("master_clear_reset input", 21'(master_clear_digital_in), 21'h000000);
        @(posedge mclk);
        master_clear_reset_pin_n <= 1'b1;
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        master_clear_reset_pin_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        check_decode(21'h0FEF80);
        @(posedge mclk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            wr(1'b1, dcwd_pkg::ADDR_CFG_ONE, rows[i].w1);
            wr(1'b1, dcwd_pkg::ADDR_CFG_TWO, rows[i].w2);
            rd(1'b1, dcwd_pkg::ADDR_CFG_ONE, rows[i].w1 | 14'h0880);
            rd(1'b1, dcwd_pkg::ADDR_CFG_TWO, rows[i].w2 | 14'h3FCF);
            pulse_reset();
            check_decode(rows[i].dec);
            $display("row %0d done", i);
        end
        wr(1'b0, dcwd_pkg::ADDR_CFG_ONE, 14'h0000);
        rd(1'b0, dcwd_pkg::ADDR_CFG_ONE, 14'h0000);
        rd(1'b1, dcwd_pkg::ADDR_CFG_ONE, 14'h3FFF);
        for (int k = 0; k < 4; k++) begin
            wr(1'b1, 14'h2000 + 14'(k), 14'h1555 + 14'(k));
        end
        for (int k = 0; k < 4; k++) begin
            rd(1'b1, 14'h2000 + 14'(k), 14'h1555 + 14'(k));
        end
        rd(1'b1, 14'h2004, 14'h0000);
        rd(1'b1, 14'h2009, 14'h0000);
        $display("access test done");
        wr(1'b1, dcwd_pkg::ADDR_CFG_ONE, 14'h0000);
        repeat (2) @(posedge mclk);
        #1;
        check("read allow", 21'(prog_mem_read_allow), 21'h000000);
        seen = 0;
        wr(1'b1, dcwd_pkg::ADDR_CFG_ONE, 14'h0040);
        wr(1'b1, dcwd_pkg::ADDR_CFG_ONE, 14'h0040);
        repeat (2) @(posedge mclk);
        #1;
        check("erase count", 21'(seen), 21'h000001);
        check("read allow", 21'(prog_mem_read_allow), 21'h000001);
        $display("protection test done");
        wr(1'b1, dcwd_pkg::ADDR_CFG_ONE, 14'h0024);
        pulse_reset();
        master_clear_reset_low(1'b1);
        wr(1'b1, dcwd_pkg::ADDR_CFG_ONE, 14'h0004);
        pulse_reset();
        master_clear_reset_low(1'b0);
        $display("master clear test done");
        finish_test();
    end
    // Whole run needs well under 600 cycles; this leaves ample margin
    initial begin
        repeat (4000) @(posedge mclk);
        n_errors++;
        finish_test();
    end
endmodule
